// ---- design/cell_pkg.sv ----
/*
  Constants, register map and mode encodings shared by the configurable logic cell.
  Assumes a 32-bit Avalon-MM register bus addressed by word index.
*/
package cell_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int LINE_COUNT = 4;
  localparam int SEL_W = 5;
  localparam int CAND_COUNT = 32;
  localparam int BUS_ADDR_W = 3;
  localparam int BUS_DATA_W = 32;
  localparam int BUS_BYTES = 4;

  // ---------------------------------------------------------------------------
  // Register word indices
  // ---------------------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_SEL0 = 3'h1;
  localparam logic [2:0] ADDR_SEL3 = 3'h4;
  localparam logic [2:0] ADDR_GATE = 3'h5;
  localparam logic [2:0] ADDR_ROUTE = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_PIN_EN_BIT = 2;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_OUT_BIT = 7;
  localparam logic [7:0] CTRL_WMASK = 8'h77;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] SEL_RESET = 5'h00;
  localparam logic [7:0] GATE_RESET = 8'h55;
  localparam int STAT_DATA_LSB = 0;
  localparam int STAT_GATED_LSB = 4;
  localparam int STAT_RESULT_BIT = 8;
  localparam int STAT_OUT_BIT = 9;

  // ---------------------------------------------------------------------------
  // Mode encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_AND_OR, FN_OR_XOR, FN_AND4, FN_SR_LATCH, FN_DFF_SR, FN_DFF2_R, FN_JK_R, FN_DLATCH_SR
  } func_mode_t;

  typedef enum logic [1:0] {GATE_LOW, GATE_PASS, GATE_INVERT, GATE_HIGH} gate_mode_t;

endpackage

// ---- design/cell_path_if.sv ----
/*
  Signal path bundle between the cell core, its input selectors and its gating stage.
  Assumes every signal is combinational and synchronous to the system clock.
*/
`timescale 1ns/1ps
interface cell_path_if #(parameter int PIN_COUNT = 8, parameter int PIN_SEL_W = 3);
  logic [cell_pkg::CAND_COUNT-1:0] cell_candidate_input;
  logic [cell_pkg::SEL_W-1:0] line_select_field [cell_pkg::LINE_COUNT];
  logic [PIN_SEL_W-1:0] pin_route_select [cell_pkg::LINE_COUNT];
  logic [PIN_COUNT-1:0] cell_pins;
  logic [cell_pkg::LINE_COUNT-1:0] cell_pin_input;
  logic [cell_pkg::LINE_COUNT-1:0] data_line;
  cell_pkg::gate_mode_t gate_mode [cell_pkg::LINE_COUNT];
  logic [cell_pkg::LINE_COUNT-1:0] gated_line;

  modport core (output cell_candidate_input, line_select_field, pin_route_select, cell_pins, gate_mode,
                input cell_pin_input, data_line, gated_line);
  modport select (input cell_candidate_input, line_select_field, pin_route_select, cell_pins,
                  output cell_pin_input, data_line);
  modport gate (input data_line, gate_mode, output gated_line);
endinterface

// ---- design/cell_line_select.sv ----
/*
  Pin routing for the four pin inputs and the four 32-to-1 data line selectors.
  Assumes the candidate vector already holds the routed pin inputs in its low bits.
*/
`timescale 1ns/1ps
module cell_line_select #(
  parameter int PIN_COUNT = 8,
  parameter int PIN_SEL_W = 3
) (
  cell_path_if.select path
);

  // Picks one pin by its route code; a code past the last pin reads low.
  function automatic logic pick_pin(input logic [PIN_COUNT-1:0] pins, input logic [PIN_SEL_W-1:0] code);
    pick_pin = (int'(code) < PIN_COUNT) ? pins[code] : 1'b0;
  endfunction

  // ---------------------------------------------------------------------------
  // Selectors
  // ---------------------------------------------------------------------------
  // Each line has its own pin route and its own data select field.
  for (genvar i = 0; i < cell_pkg::LINE_COUNT; i++) begin : g_line
    assign path.cell_pin_input[i] = pick_pin(path.cell_pins, path.pin_route_select[i]); // R12
    assign path.data_line[i] = path.cell_candidate_input[path.line_select_field[i]]; // R1 R6
  end

endmodule

// ---- design/cell_line_gate.sv ----
/*
  Gating stage: each selected data line is forced low, passed, inverted or forced high.
  Assumes the gate modes come straight from the cell's gate register.
*/
`timescale 1ns/1ps
module cell_line_gate (
  cell_path_if.gate path
);

  // Applies one gate mode to one data line.
  function automatic logic gate_line(input logic data, input cell_pkg::gate_mode_t mode);
    unique case (mode)
      cell_pkg::GATE_LOW: gate_line = 1'b0;
      cell_pkg::GATE_PASS: gate_line = data;
      cell_pkg::GATE_INVERT: gate_line = ~data;
      cell_pkg::GATE_HIGH: gate_line = 1'b1;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Gates
  // ---------------------------------------------------------------------------
  // One gate per data line, all independent.
  for (genvar i = 0; i < cell_pkg::LINE_COUNT; i++) begin : g_gate
    assign path.gated_line[i] = gate_line(path.data_line[i], path.gate_mode[i]); // R14
  end

endmodule

// ---- design/config_logic_cell.sv ----
/*
  Configurable logic cell: input selection, gating, logic function and output polarity,
  configured over an Avalon-MM slave with waitrequest.
  Assumes all candidate inputs are synchronous to clk and peer cells feed their outputs back.
*/
// Functional notes
// R1 - Four selectors each pick one of 32
// R2 - Eight selectable single-output logic functions
// R3 - Latch forms: SR, clocked D, transparent D, JK
// R4 - Stages: select, gate, function, polarity
// R5 - Settings change live without halting the cell
// R6 - Own 5-bit select field per line
// R7 - Software must program selects before use
// R8 - Codes 31 to 24: clocks and timers
// R9 - Codes 23 to 16: timers and serial
// R10 - Codes 15 to 8: PWM, capture, wave, comparators
// R11 - Codes 7 to 4: cell outputs fed back
// R12 - Codes 3 to 0: routed pin inputs
// R13 - Output goes to peripherals and a pin
// R14 - Each line excluded, passed or inverted
// R15 - Polarity one inverts, zero passes
`timescale 1ns/1ps
module config_logic_cell #(
  parameter int CELL_INDEX = 0,
  parameter int PIN_COUNT = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [cell_pkg::BUS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [cell_pkg::BUS_DATA_W-1:0] avs_writedata,
  input wire logic [cell_pkg::BUS_BYTES-1:0] avs_byteenable,
  output logic [cell_pkg::BUS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sys_osc_level,
  input wire logic fast_internal_osc,
  input wire logic slow_internal_osc,
  input wire logic converter_rc_clock,
  input wire logic pin_change_flag,
  input wire logic timer2_match,
  input wire logic timer1_overflow,
  input wire logic timer0_overflow,
  input wire logic timer6_match,
  input wire logic timer4_match,
  input wire logic async_serial_port_data,
  input wire logic async_serial_port_clock,
  input wire logic zero_cross_out,
  input wire logic osc_controller_out,
  input wire logic sync_serial_port_data,
  input wire logic sync_serial_port_clock,
  input wire logic pwm4_out,
  input wire logic pwm3_out,
  input wire logic capture_compare_unit2_out,
  input wire logic capture_compare_unit1_out,
  input wire logic complementary_wave_b,
  input wire logic complementary_wave_a,
  input wire logic comparator_sync_out2,
  input wire logic comparator_sync_out1,
  input wire logic [cell_pkg::LINE_COUNT-1:0] peer_cell_output,
  input wire logic [PIN_COUNT-1:0] cell_pins,
  output logic cell_output,
  output logic cell_output_pin,
  output logic cell_output_pin_oe
);

  localparam int PIN_SEL_W = (PIN_COUNT > 1) ? $clog2(PIN_COUNT) : 1;
  localparam int ROUTE_W = cell_pkg::LINE_COUNT * PIN_SEL_W;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic bus_ack;
  logic [7:0] ctrl_reg;
  logic [cell_pkg::SEL_W-1:0] sel_reg [cell_pkg::LINE_COUNT];
  logic [7:0] gate_reg;
  logic [ROUTE_W-1:0] route_reg;
  logic [cell_pkg::BUS_DATA_W-1:0] read_value;
  logic [cell_pkg::LINE_COUNT-1:0] fed_back_cells;
  logic [cell_pkg::LINE_COUNT-1:0] g;
  cell_pkg::func_mode_t function_mode;
  logic cell_enable;
  logic out_polarity;
  logic comb_value;
  logic function_result;
  logic is_sequential;
  logic state_q;
  logic next_state;
  logic prev_clock_line;
  logic clock_rise;

  cell_path_if #(.PIN_COUNT(PIN_COUNT), .PIN_SEL_W(PIN_SEL_W)) path ();

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Merges write data into an old word under the byte enables.
  function automatic logic [31:0] byte_merge(input logic [31:0] old_word, input logic [31:0] wr_word,
                                             input logic [3:0] be);
    logic [31:0] merged;
    merged = old_word;
    for (int b = 0; b < cell_pkg::BUS_BYTES; b++) begin
      if (be[b]) begin
        merged[b*8 +: 8] = wr_word[b*8 +: 8];
      end
    end
    byte_merge = merged;
  endfunction

  // True on the accepted edge of a write to the given word.
  function automatic logic write_hit(input logic [2:0] addr);
    write_hit = avs_write && bus_ack && (avs_address == addr);
  endfunction

  // ---------------------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------------------
  // Every access waits one cycle, then completes on the following edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
    end
  end

  // Wait is raised for the first cycle of each access.
  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  // Control word: enable, polarity, pin drive and function mode.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= cell_pkg::CTRL_RESET;
    end else if (write_hit(cell_pkg::ADDR_CTRL)) begin
      ctrl_reg <= 8'(byte_merge({24'h00_0000, ctrl_reg}, avs_writedata, avs_byteenable))
                  & cell_pkg::CTRL_WMASK; // R5
    end
  end

  // Select fields, one word per data line; reset to code zero for a known start.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < cell_pkg::LINE_COUNT; i++) begin
        sel_reg[i] <= cell_pkg::SEL_RESET; // R7
      end
    end else begin
      for (int i = 0; i < cell_pkg::LINE_COUNT; i++) begin
        if (write_hit(3'(int'(cell_pkg::ADDR_SEL0) + i))) begin
          sel_reg[i] <= 5'(byte_merge({27'h000_0000, sel_reg[i]}, avs_writedata, avs_byteenable)); // R6
        end
      end
    end
  end

  // Gate word: two bits of gate mode per line.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate_reg <= cell_pkg::GATE_RESET;
    end else if (write_hit(cell_pkg::ADDR_GATE)) begin
      gate_reg <= 8'(byte_merge({24'h00_0000, gate_reg}, avs_writedata, avs_byteenable)); // R14
    end
  end

  // Pin route word: one route code per pin input.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      route_reg <= '0;
    end else if (write_hit(cell_pkg::ADDR_ROUTE)) begin
      route_reg <= ROUTE_W'(byte_merge(32'(route_reg), avs_writedata, avs_byteenable)); // R12
    end
  end

  // Field views of the control word.
  assign cell_enable = ctrl_reg[cell_pkg::CTRL_EN_BIT];
  assign out_polarity = ctrl_reg[cell_pkg::CTRL_POL_BIT];
  assign function_mode = cell_pkg::func_mode_t'(ctrl_reg[cell_pkg::CTRL_MODE_LSB +: 3]);

  // ---------------------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------------------
  // Read word selection; unmapped bits and words read as zero.
  always_comb begin
    read_value = '0;
    case (avs_address)
      cell_pkg::ADDR_CTRL: begin
        read_value[7:0] = ctrl_reg;
        read_value[cell_pkg::CTRL_OUT_BIT] = cell_output;
      end
      cell_pkg::ADDR_GATE: begin
        read_value[7:0] = gate_reg;
      end
      cell_pkg::ADDR_ROUTE: begin
        read_value[ROUTE_W-1:0] = route_reg;
      end
      cell_pkg::ADDR_STATUS: begin
        read_value[cell_pkg::STAT_DATA_LSB +: 4] = path.data_line;
        read_value[cell_pkg::STAT_GATED_LSB +: 4] = path.gated_line;
        read_value[cell_pkg::STAT_RESULT_BIT] = function_result;
        read_value[cell_pkg::STAT_OUT_BIT] = cell_output;
      end
      default: begin
        for (int i = 0; i < cell_pkg::LINE_COUNT; i++) begin
          if (avs_address == 3'(int'(cell_pkg::ADDR_SEL0) + i)) begin
            read_value[4:0] = sel_reg[i];
          end
        end
      end
    endcase
  end

  // Read data is captured in the wait cycle and stands through the completing edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= read_value;
    end
  end

  // ---------------------------------------------------------------------------
  // Candidate inputs and selection
  // ---------------------------------------------------------------------------
  // The cell's own slot is fed from its own registered output.
  for (genvar i = 0; i < cell_pkg::LINE_COUNT; i++) begin : g_feedback
    assign fed_back_cells[i] = (i == CELL_INDEX) ? cell_output : peer_cell_output[i]; // R11
  end

  // Candidate vector, highest code first.
  assign path.cell_candidate_input = {
    sys_osc_level, fast_internal_osc, slow_internal_osc, converter_rc_clock,
    pin_change_flag, timer2_match, timer1_overflow, timer0_overflow, // R8
    timer6_match, timer4_match, async_serial_port_data, async_serial_port_clock,
    zero_cross_out, osc_controller_out, sync_serial_port_data, sync_serial_port_clock, // R9
    pwm4_out, pwm3_out, capture_compare_unit2_out, capture_compare_unit1_out,
    complementary_wave_b, complementary_wave_a, comparator_sync_out2, comparator_sync_out1, // R10
    fed_back_cells, // R11
    path.cell_pin_input // R12
  };

  // Configuration fields handed to the selector and gate stages.
  assign path.cell_pins = cell_pins;
  for (genvar i = 0; i < cell_pkg::LINE_COUNT; i++) begin : g_cfg
    assign path.line_select_field[i] = sel_reg[i];
    assign path.pin_route_select[i] = route_reg[i*PIN_SEL_W +: PIN_SEL_W];
    assign path.gate_mode[i] = cell_pkg::gate_mode_t'(gate_reg[i*2 +: 2]);
  end

  // Selection then gating, in stage order.
  cell_line_select #(.PIN_COUNT(PIN_COUNT), .PIN_SEL_W(PIN_SEL_W)) u_select (
    .path(path.select)
  ); // R4
  cell_line_gate u_gate (
    .path(path.gate)
  ); // R4

  // ---------------------------------------------------------------------------
  // Logic function
  // ---------------------------------------------------------------------------
  assign g = path.gated_line;

  // Combinational forms; inverted forms come from the polarity stage.
  always_comb begin
    is_sequential = 1'b1;
    comb_value = state_q;
    unique case (function_mode)
      cell_pkg::FN_AND_OR: begin
        is_sequential = 1'b0;
        comb_value = (g[0] & g[1]) | (g[2] & g[3]); // R2
      end
      cell_pkg::FN_OR_XOR: begin
        is_sequential = 1'b0;
        comb_value = (g[0] | g[1]) ^ (g[2] | g[3]); // R2
      end
      cell_pkg::FN_AND4: begin
        is_sequential = 1'b0;
        comb_value = &g; // R2
      end
      cell_pkg::FN_SR_LATCH, cell_pkg::FN_DFF_SR, cell_pkg::FN_DFF2_R,
      cell_pkg::FN_JK_R, cell_pkg::FN_DLATCH_SR: begin
        is_sequential = 1'b1;
        comb_value = state_q;
      end
    endcase
  end

  assign function_result = is_sequential ? state_q : comb_value;

  // Line zero clocks the edge forms; its rise is seen against the previous sample.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_clock_line <= 1'b0;
    end else begin
      prev_clock_line <= g[0];
    end
  end

  assign clock_rise = g[0] && !prev_clock_line;

  // Next state of the latch forms; reset wins over set in every form.
  always_comb begin
    next_state = state_q;
    unique case (function_mode)
      cell_pkg::FN_SR_LATCH: begin
        if (g[2] | g[3]) begin
          next_state = 1'b0;
        end else if (g[0] | g[1]) begin
          next_state = 1'b1;
        end
      end
      cell_pkg::FN_DFF_SR: begin
        if (g[2]) begin
          next_state = 1'b0;
        end else if (g[3]) begin
          next_state = 1'b1;
        end else if (clock_rise) begin
          next_state = g[1];
        end
      end
      cell_pkg::FN_DFF2_R: begin
        if (g[2]) begin
          next_state = 1'b0;
        end else if (clock_rise) begin
          next_state = g[1] & g[3];
        end
      end
      cell_pkg::FN_JK_R: begin
        if (g[2]) begin
          next_state = 1'b0;
        end else if (clock_rise) begin
          next_state = (g[1] & ~state_q) | (~g[3] & state_q);
        end
      end
      cell_pkg::FN_DLATCH_SR: begin
        if (g[2]) begin
          next_state = 1'b0;
        end else if (g[3]) begin
          next_state = 1'b1;
        end else if (g[0]) begin
          next_state = g[1];
        end
      end
      cell_pkg::FN_AND_OR, cell_pkg::FN_OR_XOR, cell_pkg::FN_AND4: begin
        next_state = state_q;
      end
    endcase
  end

  // Latch state is kept across mode changes while the cell is enabled; clearing the enable bit clears it.
  always_ff @(posedge clk) begin
    if (sys_rst || !cell_enable) begin
      state_q <= 1'b0;
    end else begin
      state_q <= next_state; // R3 R5
    end
  end

  // ---------------------------------------------------------------------------
  // Output polarity and drive
  // ---------------------------------------------------------------------------
  // Registered output; a disabled cell drives low.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cell_output <= 1'b0;
    end else begin
      cell_output <= cell_enable && (function_result ^ out_polarity); // R15 R4
    end
  end

  // The same value feeds peripherals and the pin.
  assign cell_output_pin = cell_output; // R13
  assign cell_output_pin_oe = cell_enable && ctrl_reg[cell_pkg::CTRL_PIN_EN_BIT]; // R13

endmodule

// ---- tb/cell_checker_assertions.sv ----
/*
  Checker for the logic cell's register bus handshake and output pins.
  Assumes it is bound to config_logic_cell and sees only its ports.
*/
`timescale 1ns/1ps
module cell_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic cell_output,
  input wire logic cell_output_pin,
  input wire logic cell_output_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Every access waits exactly one cycle and never while idle.
  a_wait_idle_low: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  a_wait_first_high: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle on new request");
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");

  // The pin follows the cell output, and reset leaves both quiet.
  a_pin_mirror: assert property (cell_output_pin == cell_output)
    else $error("pin differs from cell output");
  a_reset_quiet: assert property ($past(sys_rst) |-> !cell_output && !cell_output_pin_oe)
    else $error("output active after reset");
  a_oe_from_ctrl: assert property (avs_write && !avs_waitrequest && avs_address == cell_pkg::ADDR_CTRL
    && avs_byteenable[0] |=> cell_output_pin_oe == ($past(avs_writedata[0]) & $past(avs_writedata[2])))
    else $error("pin enable does not follow control write");
  a_status_out: assert property (avs_read && !avs_waitrequest && avs_address == cell_pkg::ADDR_STATUS
    |-> avs_readdata[9] == $past(cell_output) && avs_readdata[31:10] == 22'h0)
    else $error("status output bit wrong");
endmodule

bind config_logic_cell cell_checker chk_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cell_output(cell_output),
  .cell_output_pin(cell_output_pin), .cell_output_pin_oe(cell_output_pin_oe));

// ---- tb/periph_model.sv ----
/*
  Model of the peripherals that feed candidate codes 31 down to 8 into the cell.
  Assumes all sources are synchronous to the system clock.
*/
`timescale 1ns/1ps
module periph_model (
  input wire logic clk,
  input wire logic [23:0] next_src,
  output logic [23:0] src
);
  // Sources change only on the clock edge, as on-chip peripherals do.
  always_ff @(posedge clk) begin
    src <= next_src;
  end
endmodule

// ---- tb/config_logic_cell_bench.sv ----
/*
  Self-checking bench for the configurable logic cell.
  Assumes the register map and one-wait-cycle bus timing of the cell package.
*/
`timescale 1ns/1ps
module config_logic_cell_bench;
  logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, pol;
  logic [2:0] avs_address = 3'h0, mode;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd, val, cand;
  logic [3:0] avs_byteenable = 4'hf, peer = 4'h0, g;
  logic avs_waitrequest, cell_output, cell_output_pin, cell_output_pin_oe;
  logic [23:0] next_src = 24'h00_0000, src;
  logic [7:0] pins = 8'h00, gate;
  logic [11:0] route;
  logic [4:0] sel [4];
  logic [7:0] steps [17] = '{8'h63, 8'h61, 8'h68, 8'h6a, 8'h84, 8'h87, 8'h83, 8'h81, 8'h82,
    8'hc0, 8'hd7, 8'hd5, 8'hd6, 8'he7, 8'he2, 8'he4, 8'hb4};
  int errors = 0, compares = 0, seed = 32'h30a6;

  // Free-running system clock.
  always #50 clk = ~clk;

  periph_model far (.clk(clk), .next_src(next_src), .src(src));
  config_logic_cell #(.CELL_INDEX(0), .PIN_COUNT(8)) uut (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sys_osc_level(src[23]), .fast_internal_osc(src[22]), .slow_internal_osc(src[21]),
    .converter_rc_clock(src[20]), .pin_change_flag(src[19]), .timer2_match(src[18]),
    .timer1_overflow(src[17]), .timer0_overflow(src[16]), .timer6_match(src[15]), .timer4_match(src[14]),
    .async_serial_port_data(src[13]), .async_serial_port_clock(src[12]), .zero_cross_out(src[11]),
    .osc_controller_out(src[10]), .sync_serial_port_data(src[9]), .sync_serial_port_clock(src[8]),
    .pwm4_out(src[7]), .pwm3_out(src[6]), .capture_compare_unit2_out(src[5]),
    .capture_compare_unit1_out(src[4]), .complementary_wave_b(src[3]), .complementary_wave_a(src[2]),
    .comparator_sync_out2(src[1]), .comparator_sync_out1(src[0]), .peer_cell_output(peer), .cell_pins(pins),
    .cell_output(cell_output), .cell_output_pin(cell_output_pin), .cell_output_pin_oe(cell_output_pin_oe));

  task automatic finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One bus access; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) errors++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic gate_fn(input logic [1:0] c, input logic d);
    return (c == 2'h0) ? 1'b0 : (c == 2'h1) ? d : (c == 2'h2) ? !d : 1'b1;
  endfunction

  function automatic logic func_fn(input logic [2:0] m, input logic [3:0] x);
    if (m == 3'h0) return (x[0] & x[1]) | (x[2] & x[3]);
    if (m == 3'h1) return (x[0] | x[1]) ^ (x[2] | x[3]);
    return &x;
  endfunction

  // Sets a mode and gated inputs, then checks the settled output.
  task automatic step(input logic [7:0] s);
    bus(1'b1, cell_pkg::ADDR_CTRL, {24'h00_0000, 1'b0, s[7:5], 4'h1});
    next_src <= {20'h0_0000, s[4:1]};
    repeat (4) @(posedge clk);
    chk({31'h0, cell_output}, {31'h0, s[0]}, "latch output");
  endtask

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end

  // Main sequence: reset values, selection, gating and functions, latches, reset.
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, cell_pkg::ADDR_CTRL, 32'h0);
    chk(rd, {24'h0, cell_pkg::CTRL_RESET}, "ctrl reset");
    bus(1'b0, cell_pkg::ADDR_GATE, 32'h0);
    chk(rd, 32'h0000_0055, "gate reset");
    for (int it = 0; it < 40; it++) begin
      next_src <= 24'($random(seed));
      peer <= 4'($random(seed));
      pins <= 8'($random(seed));
      route = 12'($random(seed));
      bus(1'b1, cell_pkg::ADDR_ROUTE, {20'h0_0000, route});
      for (int l = 0; l < 4; l++) begin
        sel[l] = (it < 8) ? 5'(it * 4 + l) : 5'($random(seed));
        bus(1'b1, 3'(cell_pkg::ADDR_SEL0 + l), {27'h0, sel[l]});
      end
      bus(1'b0, cell_pkg::ADDR_STATUS, 32'h0);
      cand = {src, peer[3:1], 1'b0, pins[route[11:9]], pins[route[8:6]], pins[route[5:3]], pins[route[2:0]]};
      val = 32'h0;
      for (int l = 0; l < 4; l++) val[l] = cand[sel[l]];
      chk({28'h0, rd[3:0]}, val, "data lines");
    end
    for (int l = 0; l < 4; l++) bus(1'b1, 3'(cell_pkg::ADDR_SEL0 + l), 32'(8 + l));
    for (int it = 0; it < 30; it++) begin
      mode = 3'(it % 3);
      pol = 1'($random(seed));
      gate = 8'($random(seed));
      next_src <= 24'($random(seed));
      bus(1'b1, cell_pkg::ADDR_GATE, {24'h00_0000, gate});
      bus(1'b1, cell_pkg::ADDR_CTRL, {24'h00_0000, 1'b0, mode, 2'h1, pol, 1'b1});
      repeat (3) @(posedge clk);
      bus(1'b0, cell_pkg::ADDR_STATUS, 32'h0);
      for (int l = 0; l < 4; l++) g[l] = gate_fn(gate[2 * l +: 2], src[l]);
      chk({23'h0, rd[8:4]}, {23'h0, func_fn(mode, g), g}, "gated result");
      chk({31'h0, cell_output}, {31'h0, func_fn(mode, g) ^ pol}, "polarity");
      chk({31'h0, cell_output_pin_oe}, 32'h1, "pin enable");
    end
    bus(1'b1, cell_pkg::ADDR_GATE, 32'h0000_0055);
    for (int i = 0; i < 17; i++) step(steps[i]);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({31'h0, cell_output}, 32'h0, "output after reset");
    bus(1'b0, cell_pkg::ADDR_SEL3, 32'h0);
    chk(rd, {27'h0, cell_pkg::SEL_RESET}, "select after reset");
    finish_test();
  end
endmodule
